// ===== flash_array.sv
// Byte-wide flash storage array with one write port and a registered read port
module flash_array #(
  parameter int unsigned ADDR_W = 14,
  parameter int unsigned DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [ADDR_W-1:0] raddr,
  output logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rdata_ff;

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= mem[raddr];
    end
  end

  assign rdata = rdata_ff;
endmodule

// ===== flash_command_sequencer.sv
// Flash command sequencer with AHB-Lite access to control registers and array
`include "flash_seq_params.svh"
module flash_command_sequencer #(
  parameter int unsigned ERASE_CYCLES = `FLS_ERASE_CYCLES,
  parameter int unsigned ADDR_W = 14
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic exec_from_ram,
  input wire logic irq_taken,
  input wire logic low_power_mode,
  input wire logic prom_parallel_mode,
  output logic flash_busy,
  output logic flash_power_off
);
  localparam int unsigned TIMER_W = 20;
  localparam logic [TIMER_W-1:0] PROG_COUNT = TIMER_W'(`FLS_PROG_CYCLES);
  localparam logic [TIMER_W-1:0] ERASE_COUNT = TIMER_W'(ERASE_CYCLES);

  // Bus group
  flash_seq_pkg::bus_state_t bus_state_ff, nxt_bus_state;
  logic [17:0] ap_addr_ff, nxt_ap_addr;
  logic ap_write_ff, nxt_ap_write;
  logic hreadyout_ff, nxt_hreadyout;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hresp_ff;

  // Register group
  logic [3:0] seq_en_ff, nxt_seq_en;
  logic standby_ff, nxt_standby;
  logic power_off_ff, nxt_power_off;
  logic par_meta_ff, par_sync_ff;

  // Sequencer group
  flash_seq_pkg::seq_state_t seq_state_ff, nxt_seq_state;
  flash_seq_pkg::op_t op_ff, nxt_op;
  logic [TIMER_W-1:0] timer_ff, nxt_timer;
  logic [ADDR_W-1:0] walk_addr_ff, nxt_walk_addr;
  logic [14:0] walk_left_ff, nxt_walk_left;
  logic id_mode_ff, nxt_id_mode;
  logic protect_ff, nxt_protect;
  logic toggle_ff, nxt_toggle;
  logic busy_ff, nxt_busy;

  logic accept, in_data, is_flash, is_reg_space, cmd_wr, flash_rd_busy;
  logic at_unlock1, at_unlock2, at_555, mem_we;
  logic [15:0] cpu_addr;
  logic [11:0] low_addr;
  logic [7:0] wbyte, mem_wdata, mem_rdata;
  logic [ADDR_W-1:0] mem_waddr;
  assign accept = hsel && htrans[1] && hready;
  assign in_data = (bus_state_ff == flash_seq_pkg::BUS_WAIT);
  assign cpu_addr = ap_addr_ff[17:2];
  assign low_addr = cpu_addr[11:0];
  assign wbyte = hwdata[7:0];
  assign is_flash = (cpu_addr[15:14] == `FLS_AREA_SEL);
  assign is_reg_space = (ap_addr_ff[17:8] == `FLS_REG_SPACE);
  // Writes outside the enabled window leave the sequencer untouched
  assign cmd_wr = in_data && ap_write_ff && is_flash && (seq_en_ff == `FLS_SEQ_EN_ON);
  assign flash_rd_busy = in_data && !ap_write_ff && is_flash && (seq_state_ff == flash_seq_pkg::SQ_BUSY);
  assign at_555 = (low_addr == `FLS_UNLOCK1_ADDR);
  assign at_unlock1 = at_555 && (wbyte == `FLS_UNLOCK1_DATA);
  assign at_unlock2 = (low_addr == `FLS_UNLOCK2_ADDR) && (wbyte == `FLS_UNLOCK2_DATA);
  flash_array #(
    .ADDR_W(ADDR_W),
    .DATA_W(8)
  ) u_array (
    .clk(hclk),
    .rst_n(hresetn),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(haddr[ADDR_W+1:2]),
    .rdata(mem_rdata)
  );

  // One wait state on every transfer covers the registered array read
  always_comb begin
    nxt_bus_state = bus_state_ff;
    nxt_ap_addr = ap_addr_ff;
    nxt_ap_write = ap_write_ff;
    nxt_hreadyout = hreadyout_ff;
    nxt_hrdata = hrdata_ff;
    case (bus_state_ff)
      flash_seq_pkg::BUS_IDLE: begin
        if (accept) begin
          nxt_bus_state = flash_seq_pkg::BUS_WAIT;
          nxt_ap_addr = haddr[17:0];
          nxt_ap_write = hwrite;
          nxt_hreadyout = 1'b0;
        end
      end
      flash_seq_pkg::BUS_WAIT: begin
        nxt_bus_state = flash_seq_pkg::BUS_IDLE;
        nxt_hreadyout = 1'b1;
        nxt_hrdata = 32'h0000_0000;
        if (!ap_write_ff) begin
          if (is_flash) begin
            if (seq_state_ff == flash_seq_pkg::SQ_BUSY) begin
              nxt_hrdata[7:0] = `FLS_BUSY_FILL;
              nxt_hrdata[`FLS_TOGGLE_BIT] = toggle_ff;
            end else begin
              nxt_hrdata[7:0] = mem_rdata;
            end
          end else if (is_reg_space && ap_addr_ff[7:0] == `FLS_CTRL_OFS) begin
            nxt_hrdata[`FLS_SEQ_EN_LSB +: 4] = seq_en_ff;
          end else if (is_reg_space && ap_addr_ff[7:0] == `FLS_POWER_OFS) begin
            nxt_hrdata[`FLS_STANDBY_BIT] = standby_ff;
          end else if (is_reg_space && ap_addr_ff[7:0] == `FLS_STATUS_OFS) begin
            nxt_hrdata[`FLS_STAT_BUSY] = busy_ff;
            nxt_hrdata[`FLS_STAT_PROTECT] = protect_ff;
            nxt_hrdata[`FLS_STAT_ID_MODE] = id_mode_ff;
            nxt_hrdata[`FLS_STAT_STANDBY] = standby_ff;
            nxt_hrdata[`FLS_STAT_PARALLEL] = par_sync_ff;
          end
        end
      end
      default: begin
        nxt_bus_state = flash_seq_pkg::BUS_IDLE;
        nxt_hreadyout = 1'b1;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_ff <= flash_seq_pkg::BUS_IDLE;
      ap_addr_ff <= 18'h0_0000;
      ap_write_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
      hresp_ff <= 1'b0;
    end else begin
      bus_state_ff <= nxt_bus_state;
      ap_addr_ff <= nxt_ap_addr;
      ap_write_ff <= nxt_ap_write;
      hreadyout_ff <= nxt_hreadyout;
      hrdata_ff <= nxt_hrdata;
      hresp_ff <= 1'b0;
    end
  end

  // Control and standby registers
  always_comb begin
    nxt_seq_en = seq_en_ff;
    nxt_standby = standby_ff;
    if (in_data && ap_write_ff && is_reg_space) begin
      if (ap_addr_ff[7:0] == `FLS_CTRL_OFS) begin
        nxt_seq_en = hwdata[`FLS_SEQ_EN_LSB +: 4];
      end else if (ap_addr_ff[7:0] == `FLS_POWER_OFS) begin
        // Code fetched from flash cannot switch flash off under itself
        nxt_standby = hwdata[`FLS_STANDBY_BIT] && exec_from_ram;
      end
    end
    if (in_data && is_flash) begin
      nxt_standby = 1'b0;
    end
    if (irq_taken || low_power_mode) begin
      nxt_standby = 1'b0;
    end
    // Low-power modes cut current whatever the bit holds
    nxt_power_off = nxt_standby || low_power_mode;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_en_ff <= `FLS_SEQ_EN_RESET;
      standby_ff <= 1'b0;
      power_off_ff <= 1'b0;
      par_meta_ff <= 1'b0;
      par_sync_ff <= 1'b0;
    end else begin
      seq_en_ff <= nxt_seq_en;
      standby_ff <= nxt_standby;
      power_off_ff <= nxt_power_off;
      par_meta_ff <= prom_parallel_mode;
      par_sync_ff <= par_meta_ff;
    end
  end

  // Command sequencer and program/erase engine
  always_comb begin
    nxt_seq_state = seq_state_ff;
    nxt_op = op_ff;
    nxt_timer = timer_ff;
    nxt_walk_addr = walk_addr_ff;
    nxt_walk_left = walk_left_ff;
    nxt_id_mode = id_mode_ff;
    nxt_protect = protect_ff;
    nxt_toggle = toggle_ff;
    mem_we = 1'b0;
    mem_waddr = walk_addr_ff;
    mem_wdata = `FLS_ERASED_BYTE;
    if (seq_state_ff == flash_seq_pkg::SQ_BUSY) begin
      // Command writes are dropped until the operation ends
      if (timer_ff != '0) begin
        nxt_timer = timer_ff - TIMER_W'(1);
      end
      if (walk_left_ff != 15'h0000) begin
        mem_we = 1'b1;
        nxt_walk_addr = walk_addr_ff + ADDR_W'(1);
        nxt_walk_left = walk_left_ff - 15'h0001;
      end
      if (flash_rd_busy) begin
        nxt_toggle = !toggle_ff;
      end
      if (timer_ff == '0 && walk_left_ff == 15'h0000) begin
        nxt_seq_state = flash_seq_pkg::SQ_IDLE;
        if (op_ff == flash_seq_pkg::OP_CHIP) begin
          nxt_protect = 1'b0;
        end
      end
    end else if (cmd_wr) begin
      nxt_seq_state = flash_seq_pkg::SQ_IDLE;
      case (seq_state_ff)
        flash_seq_pkg::SQ_IDLE: begin
          if (at_unlock1) begin
            nxt_seq_state = flash_seq_pkg::SQ_U1;
          end else if (wbyte == `FLS_CMD_ID_EXIT) begin
            nxt_id_mode = 1'b0;
          end
        end
        flash_seq_pkg::SQ_U1: begin
          if (at_unlock2) begin
            nxt_seq_state = flash_seq_pkg::SQ_U2;
          end
        end
        flash_seq_pkg::SQ_U2: begin
          if (at_555) begin
            if (wbyte == `FLS_CMD_PROGRAM) begin
              nxt_seq_state = flash_seq_pkg::SQ_PROG;
            end else if (wbyte == `FLS_CMD_PROTECT) begin
              nxt_seq_state = flash_seq_pkg::SQ_PROT;
            end else if (wbyte == `FLS_CMD_ERASE) begin
              nxt_seq_state = flash_seq_pkg::SQ_E3;
            end else if (wbyte == `FLS_CMD_ID_ENTRY) begin
              nxt_id_mode = 1'b1;
            end else if (wbyte == `FLS_CMD_ID_EXIT) begin
              nxt_id_mode = 1'b0;
            end
          end
        end
        flash_seq_pkg::SQ_PROG: begin
          // Target byte uses the full address, not the low 12 bits
          mem_we = 1'b1;
          mem_waddr = cpu_addr[ADDR_W-1:0];
          mem_wdata = wbyte;
          nxt_seq_state = flash_seq_pkg::SQ_BUSY;
          nxt_op = flash_seq_pkg::OP_PROGRAM;
          nxt_timer = PROG_COUNT;
          nxt_walk_left = 15'h0000;
          nxt_toggle = 1'b1;
        end
        flash_seq_pkg::SQ_PROT: begin
          if (cpu_addr == `FLS_PROTECT_ADDR && wbyte == `FLS_PROTECT_DATA) begin
            nxt_seq_state = flash_seq_pkg::SQ_BUSY;
            nxt_op = flash_seq_pkg::OP_PROTECT;
            nxt_protect = 1'b1;
            nxt_timer = PROG_COUNT;
            nxt_walk_left = 15'h0000;
            nxt_toggle = 1'b1;
          end
        end
        flash_seq_pkg::SQ_E3: begin
          if (at_unlock1) begin
            nxt_seq_state = flash_seq_pkg::SQ_E4;
          end
        end
        flash_seq_pkg::SQ_E4: begin
          if (at_unlock2) begin
            nxt_seq_state = flash_seq_pkg::SQ_E5;
          end
        end
        flash_seq_pkg::SQ_E5: begin
          if (wbyte == `FLS_CMD_SECTOR && !par_sync_ff) begin
            nxt_seq_state = flash_seq_pkg::SQ_BUSY;
            nxt_op = flash_seq_pkg::OP_SECTOR;
            nxt_walk_addr = {cpu_addr[ADDR_W-1:12], 12'h000};
            nxt_walk_left = `FLS_SECTOR_BYTES;
            nxt_timer = ERASE_COUNT;
            nxt_toggle = 1'b1;
          end else if (at_555 && wbyte == `FLS_CMD_CHIP) begin
            nxt_seq_state = flash_seq_pkg::SQ_BUSY;
            nxt_op = flash_seq_pkg::OP_CHIP;
            nxt_walk_addr = '0;
            nxt_walk_left = `FLS_ARRAY_BYTES;
            nxt_timer = ERASE_COUNT;
            nxt_toggle = 1'b1;
          end
        end
        default: begin
          nxt_seq_state = flash_seq_pkg::SQ_IDLE;
        end
      endcase
    end
    nxt_busy = (nxt_seq_state == flash_seq_pkg::SQ_BUSY);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_state_ff <= flash_seq_pkg::SQ_IDLE;
      op_ff <= flash_seq_pkg::OP_PROGRAM;
      timer_ff <= '0;
      walk_addr_ff <= '0;
      walk_left_ff <= 15'h0000;
      id_mode_ff <= 1'b0;
      protect_ff <= 1'b0;
      toggle_ff <= 1'b1;
      busy_ff <= 1'b0;
    end else begin
      seq_state_ff <= nxt_seq_state;
      op_ff <= nxt_op;
      timer_ff <= nxt_timer;
      walk_addr_ff <= nxt_walk_addr;
      walk_left_ff <= nxt_walk_left;
      id_mode_ff <= nxt_id_mode;
      protect_ff <= nxt_protect;
      toggle_ff <= nxt_toggle;
      busy_ff <= nxt_busy;
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign flash_busy = busy_ff;
  assign flash_power_off = power_off_ff;
endmodule

// ===== flash_command_sequencer_properties.sv
// Port checker for the flash command sequencer
module flash_command_sequencer_checker #(
  parameter int unsigned ERASE_CYCLES = 20,
  parameter int unsigned ADDR_W = 14
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic exec_from_ram,
  input wire logic irq_taken,
  input wire logic low_power_mode,
  input wire logic prom_parallel_mode,
  input wire logic flash_busy,
  input wire logic flash_power_off
);
  // Full-chip erase walks every byte, so it may outlast the timer
  localparam int unsigned BUSY_MAX = (ERASE_CYCLES > 16384 ? ERASE_CYCLES : 16384) + 4;
  logic take;
  logic wr_d_ff;
  logic rd_arr_ff;
  logic nxt_wr_d;
  logic nxt_rd_arr;
  int unsigned busy_cnt_ff;
  int unsigned nxt_busy_cnt;
  assign take = hsel && htrans[1] && hready;
  always_comb begin
    nxt_wr_d = take && hwrite;
    nxt_rd_arr = take && !hwrite && haddr[17:16] == 2'h3;
    nxt_busy_cnt = flash_busy ? busy_cnt_ff + 1 : 0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_d_ff <= 1'b0;
      rd_arr_ff <= 1'b0;
      busy_cnt_ff <= 0;
    end else begin
      wr_d_ff <= nxt_wr_d;
      rd_arr_ff <= nxt_rd_arr;
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_ONE_WAIT: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("wait state count wrong");
  AST_IDLE_READY: assert property (hreadyout && !take |=> hreadyout)
    else $error("ready dropped without a transfer");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("response not okay");
  AST_BUSY_CAUSE: assert property ($rose(flash_busy) |-> $past(wr_d_ff) || $past(wr_d_ff, 2))
    else $error("busy rose without a write");
  AST_BUSY_LIMIT: assert property (busy_cnt_ff <= BUSY_MAX)
    else $error("operation ran too long");
  AST_BUSY_READ: assert property (rd_arr_ff && flash_busy ##1 flash_busy |-> (hrdata[7:0] | 8'h40) == 8'hFF)
    else $error("array data served while busy");
  AST_LP_OFF: assert property (low_power_mode |=> flash_power_off)
    else $error("low power left flash on");
  AST_IRQ_CLR: assert property (irq_taken ##1 !low_power_mode [*2] |-> !flash_power_off)
    else $error("interrupt kept standby");
  AST_ACC_CLR: assert property (take && haddr[17:16] == 2'h3 ##1 !low_power_mode [*3] |-> !flash_power_off)
    else $error("array access kept standby");
  AST_RAM_SET: assert property ($rose(flash_power_off) |-> $past(low_power_mode) || $past(exec_from_ram))
    else $error("standby set from flash code");
endmodule

bind flash_command_sequencer flash_command_sequencer_checker #(.ERASE_CYCLES(ERASE_CYCLES), .ADDR_W(ADDR_W)) chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .exec_from_ram(exec_from_ram), .irq_taken(irq_taken), .low_power_mode(low_power_mode),
  .prom_parallel_mode(prom_parallel_mode), .flash_busy(flash_busy), .flash_power_off(flash_power_off));

// ===== flash_command_sequencer_tb_top.sv
// Register and command sequence tests for the flash sequencer
module flash_command_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, flash_busy, flash_power_off;
  logic exec_from_ram, irq_taken, low_power_mode, prom_parallel_mode;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] d0, d1;
  logic [15:0] al [4] = '{16'hC000, 16'hC400, 16'hE555, 16'hFFFF};
  int bad_count, num_checks, n;
  time t0;
  initial hclk = 1'b0;
  always #20 hclk = ~hclk;
  flash_command_sequencer #(.ERASE_CYCLES(20)) flash_command_sequencer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .exec_from_ram(exec_from_ram), .irq_taken(irq_taken), .low_power_mode(low_power_mode),
    .prom_parallel_mode(prom_parallel_mode), .flash_busy(flash_busy), .flash_power_off(flash_power_off));
  flash_cpu_master flash_cpu_master_i (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  function automatic logic [31:0] fa(input logic [15:0] a);
    return {14'h0, a, 2'h0};
  endfunction
  task automatic print_verdict;
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] r;
    bit ok;
    flash_cpu_master_i.xfer(w, a, {24'h0, d}, r, ok);
    q = r[7:0];
    if (!ok) begin
      bad_count++;
      $display("BAD %0t: bus hung", $time);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] q;
    xf(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a, output logic [7:0] q);
    xf(1'b0, a, 8'h00, q);
  endtask
  task automatic cmd(input logic [3:0] hi, input logic [7:0] code);
    wr(fa({hi, 12'h555}), 8'hAA);
    wr(fa({hi, 12'hAAA}), 8'h55);
    wr(fa({hi, 12'h555}), code);
  endtask
  task automatic erase(input logic [3:0] hi, input logic [15:0] sa, input logic [7:0] code);
    cmd(hi, 8'h80);
    wr(fa({hi, 12'h555}), 8'hAA);
    wr(fa({hi, 12'hAAA}), 8'h55);
    wr(fa(sa), code);
  endtask
  // Read one place until two reads agree; first read shows the toggle bit set
  task automatic poll(input logic [15:0] a);
    rd(fa(a), d0);
    chk({7'h0, d0[6]}, 8'h01);
    for (n = 0; n < 6000; n++) begin
      rd(fa(a), d1);
      if (d1 === d0) break;
      d0 = d1;
    end
    chk({7'h0, n < 6000}, 8'h01);
  endtask
  initial begin
    hresetn = 1'b0;
    exec_from_ram = 1'b0;
    irq_taken = 1'b0;
    low_power_mode = 1'b0;
    prom_parallel_mode = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({6'h0, flash_busy, flash_power_off}, 8'h00);
    rd(32'h0, d0);
    chk(d0 & 8'hF0, 8'hC0);
    rd(32'hC, d0);
    chk(d0, 8'h00);
    $display("reset test done");
    wr(32'h0, 8'h30);
    erase(4'hF, 16'hF555, 8'h10);
    cmd(4'hC, 8'hA0);
    wr(fa(16'hC400), 8'h00);
    poll(16'hC000);
    foreach (al[i]) begin
      rd(fa(al[i]), d0);
      chk(d0, 8'hFF);
    end
    cmd(4'hE, 8'hA0);
    wr(fa(16'hC123), 8'h5A);
    t0 = $time;
    poll(16'hC123);
    chk({7'h0, ($time - t0) <= 64'd1016 * 40}, 8'h01);
    rd(fa(16'hC123), d0);
    chk(d0, 8'h5A);
    $display("chip erase and program test done");
    cmd(4'hC, 8'h77);
    wr(fa(16'hC200), 8'h11);
    rd(fa(16'hC200), d0);
    chk({d0[7:1], flash_busy}, 8'hFE);
    cmd(4'hC, 8'hA0);
    wr(fa(16'hD000), 8'h33);
    poll(16'hD000);
    erase(4'hC, 16'hC7F0, 8'h30);
    poll(16'hC000);
    rd(fa(16'hC123), d0);
    chk(d0, 8'hFF);
    rd(fa(16'hD000), d0);
    chk(d0, 8'h33);
    // Pin is synchronised, so give it time to land before the sequence
    prom_parallel_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    erase(4'hC, 16'hD010, 8'h30);
    @(posedge hclk);
    chk({7'h0, flash_busy}, 8'h00);
    prom_parallel_mode <= 1'b0;
    rd(fa(16'hD000), d0);
    chk(d0, 8'h33);
    wr(32'h0, 8'hC0);
    cmd(4'hC, 8'hA0);
    wr(fa(16'hC300), 8'h22);
    rd(fa(16'hC300), d0);
    chk({d0[7:1], flash_busy}, 8'hFE);
    wr(32'h0, 8'h30);
    $display("erase and lock test done");
    cmd(4'hF, 8'h90);
    rd(32'h8, d0);
    chk(d0 & 8'h04, 8'h04);
    wr(fa(16'hF123), 8'hF0);
    rd(32'h8, d0);
    chk(d0 & 8'h04, 8'h00);
    cmd(4'hF, 8'h90);
    cmd(4'hF, 8'hF0);
    rd(32'h8, d0);
    chk(d0 & 8'h04, 8'h00);
    cmd(4'hF, 8'hA5);
    wr(fa(16'hEF7F), 8'h00);
    rd(32'h8, d0);
    chk(d0 & 8'h03, 8'h00);
    cmd(4'hF, 8'hA5);
    wr(fa(16'hFF7F), 8'h00);
    poll(16'hFF7F);
    rd(32'h8, d0);
    chk(d0 & 8'h03, 8'h02);
    $display("id and protect test done");
    wr(32'h4, 8'h01);
    rd(32'h8, d0);
    chk(d0 & 8'h08, 8'h00);
    exec_from_ram <= 1'b1;
    wr(32'h4, 8'h01);
    rd(32'h8, d0);
    chk({d0[3], flash_power_off}, 8'h03);
    rd(fa(16'hC000), d1);
    rd(32'h8, d0);
    chk(d0 & 8'h08, 8'h00);
    wr(32'h4, 8'h01);
    irq_taken <= 1'b1;
    @(posedge hclk);
    irq_taken <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({7'h0, flash_power_off}, 8'h00);
    wr(32'h4, 8'h01);
    low_power_mode <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({7'h0, flash_power_off}, 8'h01);
    low_power_mode <= 1'b0;
    rd(32'h8, d0);
    chk(d0 & 8'h08, 8'h00);
    wr(32'h4, 8'h01);
    wr(32'h4, 8'h00);
    rd(32'h8, d0);
    chk({d0[3], flash_power_off}, 8'h00);
    exec_from_ram <= 1'b0;
    $display("standby test done");
    print_verdict();
  end
endmodule

// ===== flash_cpu_master.sv
// CPU core model issuing single-word bus transfers
module flash_cpu_master (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  task automatic wait_rdy(output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge hclk);
      ok = hready === 1'b1;
    end
  endtask
  // Entered just after an edge; bus released data shows its inverse
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output bit ok);
    bit k1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy(k1);
    htrans <= 2'h0;
    hwdata <= w ? wd : ~hwdata;
    wait_rdy(ok);
    ok = ok && k1;
    rd = hrdata;
    if (w) hwdata <= ~wd;
  endtask
endmodule

// ===== flash_seq_params.svh
// Offsets, field positions, reset values and timing counts of the flash sequencer
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH
`define FLS_CTRL_OFS 8'h00
`define FLS_POWER_OFS 8'h04
`define FLS_STATUS_OFS 8'h08
`define FLS_REG_SPACE 10'h000
`define FLS_AREA_SEL 2'h3
`define FLS_SEQ_EN_LSB 4
`define FLS_SEQ_EN_RESET 4'hC
`define FLS_SEQ_EN_ON 4'h3
`define FLS_STANDBY_BIT 0
`define FLS_STAT_BUSY 0
`define FLS_STAT_PROTECT 1
`define FLS_STAT_ID_MODE 2
`define FLS_STAT_STANDBY 3
`define FLS_STAT_PARALLEL 4
`define FLS_UNLOCK1_ADDR 12'h555
`define FLS_UNLOCK2_ADDR 12'hAAA
`define FLS_UNLOCK1_DATA 8'hAA
`define FLS_UNLOCK2_DATA 8'h55
`define FLS_CMD_PROGRAM 8'hA0
`define FLS_CMD_ERASE 8'h80
`define FLS_CMD_ID_ENTRY 8'h90
`define FLS_CMD_ID_EXIT 8'hF0
`define FLS_CMD_PROTECT 8'hA5
`define FLS_CMD_SECTOR 8'h30
`define FLS_CMD_CHIP 8'h10
`define FLS_PROTECT_ADDR 16'hFF7F
`define FLS_PROTECT_DATA 8'h00
`define FLS_ERASED_BYTE 8'hFF
`define FLS_TOGGLE_BIT 6
`define FLS_BUSY_FILL 8'hBF
`define FLS_SECTOR_BYTES 15'h1000
`define FLS_ARRAY_BYTES 15'h4000
`define FLS_CLK_MHZ 25
`define FLS_PROG_TIME_US 40
`define FLS_PROG_CYCLES (`FLS_PROG_TIME_US * `FLS_CLK_MHZ)
`define FLS_ERASE_TIME_MS 30
`define FLS_ERASE_CYCLES (`FLS_ERASE_TIME_MS * 1000 * `FLS_CLK_MHZ)
`endif

// ===== flash_seq_pkg.sv
// Types shared by the flash sequencer files
package flash_seq_pkg;
  typedef enum logic [8:0] {
    SQ_IDLE = 9'h001,
    SQ_U1 = 9'h002,
    SQ_U2 = 9'h004,
    SQ_PROG = 9'h008,
    SQ_PROT = 9'h010,
    SQ_E3 = 9'h020,
    SQ_E4 = 9'h040,
    SQ_E5 = 9'h080,
    SQ_BUSY = 9'h100
  } seq_state_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_WAIT = 2'h2
  } bus_state_t;

  typedef enum logic [3:0] {
    OP_PROGRAM = 4'h1,
    OP_SECTOR = 4'h2,
    OP_CHIP = 4'h4,
    OP_PROTECT = 4'h8
  } op_t;
endpackage
